// file: hbc_pkg.sv
// Constants, codes and carrier types of the holding brake control block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package hbc_pkg;

  // Parameter space offset of the brake override mode.
  localparam logic [15:0] ADDR_BRAKE_OVERRIDE_MODE = 16'h0814;
  localparam logic [15:0] RESET_BRAKE_OVERRIDE_MODE = 16'h0000;

  // Brake override mode encodings.
  localparam logic [1:0] MODE_AUTOMATIC = 2'h0;
  localparam logic [1:0] MODE_MANUAL_RELEASE = 2'h1;
  localparam logic [1:0] MODE_MANUAL_APPLY = 2'h2;

  // Operating state codes reported by the drive state machine.
  localparam logic [3:0] OPST_SWITCH_ON_DISABLED = 4'h3;
  localparam logic [3:0] OPST_READY_TO_SWITCH_ON = 4'h4;
  localparam logic [3:0] OPST_OPERATION_ENABLED = 4'h6;
  localparam logic [3:0] OPST_FAULT = 4'h9;

  // Error code reported when safe torque off has cut the power stage.
  localparam logic [15:0] ERR_SAFE_TORQUE_OFF = 16'h0514;
  localparam logic [15:0] ERR_NONE = 16'h0000;

  // Brake delays are given in milliseconds; the clock period is 10 ns.
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_UNIT_NS = 1000000;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;

  // Number of limit switch inputs.
  localparam int LIMIT_COUNT = 2;

  // Reset level of the synchronised pins: inactive torque off inputs high.
  // Field order is torque_off_input_a, torque_off_input_b, brake_release_input,
  // limit_level, so both torque off bits high and the release request low.
  localparam logic [LIMIT_COUNT+2:0] PIN_RESET_LEVEL = 5'h18;

  // Pins that arrive from outside the clock domain.
  typedef struct packed {
    logic torque_off_input_a;
    logic torque_off_input_b;
    logic brake_release_input;
    logic [LIMIT_COUNT-1:0] limit_level;
  } hbc_pins_t;

  // Static configuration of each limit switch.
  typedef struct packed {
    logic [LIMIT_COUNT-1:0] enable;
    logic [LIMIT_COUNT-1:0] normally_closed;
  } hbc_limit_cfg_t;

  typedef enum logic [1:0] {
    MODE_E_AUTOMATIC = MODE_AUTOMATIC,
    MODE_E_RELEASE = MODE_MANUAL_RELEASE,
    MODE_E_APPLY = MODE_MANUAL_APPLY
  } hbc_mode_t;

endpackage

// file: hbc_pin_sync.sv
// Three-stage synchroniser for a group of pin inputs.
// A change is taken once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module hbc_pin_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        nxt_q[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : q_ff[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_ff <= RESET_LEVEL;
      s2_ff <= RESET_LEVEL;
      s3_ff <= RESET_LEVEL;
      q_ff <= RESET_LEVEL;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign o_sync = q_ff;
endmodule // hbc_pin_sync
`default_nettype wire

// file: hbc_delay_timer.sv
// Millisecond delay timer for the brake release and application delays.
// A start pulse loads the delay; done stays high until the next start.
`timescale 1ns/100ps
`default_nettype none
module hbc_delay_timer #(
  parameter int CYCLES_PER_UNIT = hbc_pkg::DELAY_UNIT_CYCLES,
  parameter int DW = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [DW-1:0] i_delay,
  output logic o_done
);
  localparam int PW = (CYCLES_PER_UNIT > 1) ? $clog2(CYCLES_PER_UNIT) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_UNIT - 1);

  logic busy_ff;
  logic nxt_busy;
  logic done_ff;
  logic nxt_done;
  logic [PW-1:0] pre_ff;
  logic [PW-1:0] nxt_pre;
  logic [DW-1:0] left_ff;
  logic [DW-1:0] nxt_left;

  always_comb begin
    nxt_busy = busy_ff;
    nxt_done = done_ff;
    nxt_pre = pre_ff;
    nxt_left = left_ff;
    if (i_start) begin
      nxt_busy = 1'b1;
      nxt_done = 1'b0;
      nxt_pre = '0;
      nxt_left = i_delay;
    end else if (busy_ff) begin
      if (left_ff == '0) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else if (pre_ff == PRE_LAST) begin
        nxt_pre = '0;
        nxt_left = left_ff - DW'(1);
      end else begin
        nxt_pre = pre_ff + PW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      pre_ff <= '0;
      left_ff <= '0;
    end else begin
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      pre_ff <= nxt_pre;
      left_ff <= nxt_left;
    end
  end

  assign o_done = done_ff;
endmodule // hbc_delay_timer
`default_nettype wire

// file: hbc_brake_ctrl.sv
// Holding brake control: power stage sequencing with brake delays, manual
// brake override, safe torque off and limit switch error reporting.
// Assumes drive state, standstill and enable request come from same-clock
// logic, and that the pins in i_pins are asynchronous.
//
// Notes on behaviour
// - Enabling the power stage releases the brake automatically unless overridden.
// - Operation enabled is permitted only after the release delay has elapsed.
// - Disabling the power stage applies the brake automatically.
// - Motor current stays on during the apply delay, removed afterwards.
// - Manual release works only in states 3, 4 and 9.
// - Manual application is accepted only at motor standstill.
// - Enabling with manual application active keeps the brake applied.
// - Manual application beats automatic release and manual release.
// - Override mode 0 automatic, 1 manual release, 2 manual apply.
// - Apply to release needs automatic first; direct change is no release.
// - A new override value acts at once.
// - The release input requests manual release under the same restrictions.
// - Safe torque off disables the power stage and reports error 1300.
// - Limit switch triggers raise errors; each is enable and polarity set.
`timescale 1ns/100ps
`default_nettype none
module hbc_brake_ctrl #(
  parameter int DELAY_UNIT_CYCLES = hbc_pkg::DELAY_UNIT_CYCLES,
  parameter int DELAY_W = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire hbc_pkg::hbc_pins_t i_pins,
  input wire hbc_pkg::hbc_limit_cfg_t i_limit_cfg,
  input wire logic i_enable_req,
  input wire logic [3:0] i_op_state,
  input wire logic i_standstill,
  input wire logic i_fault_reset,
  input wire logic [DELAY_W-1:0] i_release_delay,
  input wire logic [DELAY_W-1:0] i_apply_delay,
  input wire logic i_par_sel,
  input wire logic i_par_wr,
  input wire logic [15:0] i_par_addr,
  input wire logic [15:0] i_par_wdata,
  output logic [15:0] o_par_rdata,
  output logic o_par_ack,
  output logic o_par_err,
  output logic o_brake_release,
  output logic o_motor_current,
  output logic o_op_enable_allowed,
  output logic o_sto_fault,
  output logic [15:0] o_error_code,
  output logic [hbc_pkg::LIMIT_COUNT-1:0] o_limit_error
);
  localparam int PINW = $bits(hbc_pkg::hbc_pins_t);
  localparam int LN = hbc_pkg::LIMIT_COUNT;

  typedef enum logic [1:0] {
    HBC_PS_OFF,
    HBC_PS_RELEASING,
    HBC_PS_ON,
    HBC_PS_APPLYING
  } hbc_power_t;

  hbc_pkg::hbc_pins_t pins;
  logic [PINW-1:0] pins_vec;
  logic timer_start;
  logic [DELAY_W-1:0] timer_delay;
  logic timer_done;
  logic sto_trig;

  hbc_pin_sync #(
    .WIDTH(PINW),
    .RESET_LEVEL(hbc_pkg::PIN_RESET_LEVEL)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_pins),
    .o_sync(pins_vec)
  );
  assign pins = hbc_pkg::hbc_pins_t'(pins_vec);

  hbc_delay_timer #(
    .CYCLES_PER_UNIT(DELAY_UNIT_CYCLES),
    .DW(DELAY_W)
  ) u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(timer_start),
    .i_delay(timer_delay),
    .o_done(timer_done)
  );

  // Torque off inputs are active low: either one low cuts the power stage.
  assign sto_trig = ~pins.torque_off_input_a | ~pins.torque_off_input_b;

  // Parameter access port.
  hbc_pkg::hbc_mode_t mode_ff;
  hbc_pkg::hbc_mode_t nxt_mode;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic ack_ff;
  logic nxt_ack;
  logic err_ff;
  logic nxt_err;
  logic hit;

  always_comb begin
    hit = (i_par_addr == hbc_pkg::ADDR_BRAKE_OVERRIDE_MODE);
    nxt_mode = mode_ff;
    nxt_rdata = '0;
    nxt_ack = i_par_sel;
    nxt_err = 1'b0;
    if (i_par_sel) begin
      if (!hit) begin
        nxt_err = 1'b1;
      end else if (i_par_wr) begin
        case (i_par_wdata)
          16'h0000: nxt_mode = hbc_pkg::MODE_E_AUTOMATIC;
          16'h0001: nxt_mode = hbc_pkg::MODE_E_RELEASE;
          16'h0002: nxt_mode = hbc_pkg::MODE_E_APPLY;
          default: nxt_err = 1'b1;
        endcase
      end else begin
        nxt_rdata = {14'h0000, mode_ff};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_ff <= hbc_pkg::hbc_mode_t'(hbc_pkg::RESET_BRAKE_OVERRIDE_MODE[1:0]);
      rdata_ff <= '0;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
    end
  end

  // Manual override state.
  logic apply_ff;
  logic nxt_apply;
  logic manual_release_ok;
  logic release_state_ok;

  always_comb begin
    release_state_ok = (i_op_state == hbc_pkg::OPST_SWITCH_ON_DISABLED) ||
                       (i_op_state == hbc_pkg::OPST_READY_TO_SWITCH_ON) ||
                       (i_op_state == hbc_pkg::OPST_FAULT);
    if (apply_ff) begin
      // Only a return to automatic ends an active manual application.
      nxt_apply = (mode_ff != hbc_pkg::MODE_E_AUTOMATIC);
    end else begin
      nxt_apply = (mode_ff == hbc_pkg::MODE_E_APPLY) && i_standstill;
    end
    manual_release_ok = ((mode_ff == hbc_pkg::MODE_E_RELEASE) ||
                         pins.brake_release_input) &&
                        release_state_ok && !apply_ff;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      apply_ff <= 1'b0;
    end else begin
      apply_ff <= nxt_apply;
    end
  end

  // Power stage sequencing with brake delays.
  hbc_power_t ps_ff;
  hbc_power_t nxt_ps;
  logic brake_ff;
  logic nxt_brake;
  logic current_ff;
  logic nxt_current;
  logic allowed_ff;
  logic nxt_allowed;

  always_comb begin
    nxt_ps = ps_ff;
    timer_start = 1'b0;
    timer_delay = i_release_delay;
    case (ps_ff)
      HBC_PS_OFF: begin
        if (i_enable_req && !sto_trig) begin
          nxt_ps = HBC_PS_RELEASING;
          timer_start = 1'b1;
        end
      end
      HBC_PS_RELEASING: begin
        if (sto_trig) begin
          nxt_ps = HBC_PS_OFF;
        end else if (!i_enable_req) begin
          nxt_ps = HBC_PS_APPLYING;
          timer_start = 1'b1;
          timer_delay = i_apply_delay;
        end else if (timer_done) begin
          nxt_ps = HBC_PS_ON;
        end
      end
      HBC_PS_ON: begin
        if (sto_trig) begin
          nxt_ps = HBC_PS_OFF;
        end else if (!i_enable_req) begin
          nxt_ps = HBC_PS_APPLYING;
          timer_start = 1'b1;
          timer_delay = i_apply_delay;
        end
      end
      HBC_PS_APPLYING: begin
        if (sto_trig || timer_done) begin
          nxt_ps = HBC_PS_OFF;
        end
      end
      default: nxt_ps = HBC_PS_OFF;
    endcase
    nxt_current = (nxt_ps != HBC_PS_OFF);
    nxt_allowed = (nxt_ps == HBC_PS_ON);
    nxt_brake = !nxt_apply &&
                ((nxt_ps == HBC_PS_RELEASING) || (nxt_ps == HBC_PS_ON) ||
                 manual_release_ok);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ps_ff <= HBC_PS_OFF;
      brake_ff <= 1'b0;
      current_ff <= 1'b0;
      allowed_ff <= 1'b0;
    end else begin
      ps_ff <= nxt_ps;
      brake_ff <= nxt_brake;
      current_ff <= nxt_current;
      allowed_ff <= nxt_allowed;
    end
  end

  // Error reporting; a new trigger wins over a fault reset.
  logic sto_fault_ff;
  logic nxt_sto_fault;
  logic [15:0] err_code_ff;
  logic [15:0] nxt_err_code;
  logic [LN-1:0] limit_ff;
  logic [LN-1:0] nxt_limit;
  logic [LN-1:0] limit_hit;

  genvar g;
  generate
    for (g = 0; g < LN; g++) begin : g_limit
      always_comb begin
        limit_hit[g] = i_limit_cfg.enable[g] &&
                       (i_limit_cfg.normally_closed[g] ?
                        !pins.limit_level[g] : pins.limit_level[g]);
        nxt_limit[g] = limit_hit[g] || (limit_ff[g] && !i_fault_reset);
      end
    end
  endgenerate

  always_comb begin
    nxt_sto_fault = sto_trig || (sto_fault_ff && !i_fault_reset);
    nxt_err_code = nxt_sto_fault ? hbc_pkg::ERR_SAFE_TORQUE_OFF :
                                   hbc_pkg::ERR_NONE;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sto_fault_ff <= 1'b0;
      err_code_ff <= hbc_pkg::ERR_NONE;
      limit_ff <= '0;
    end else begin
      sto_fault_ff <= nxt_sto_fault;
      err_code_ff <= nxt_err_code;
      limit_ff <= nxt_limit;
    end
  end

  assign o_par_rdata = rdata_ff;
  assign o_par_ack = ack_ff;
  assign o_par_err = err_ff;
  assign o_brake_release = brake_ff;
  assign o_motor_current = current_ff;
  assign o_op_enable_allowed = allowed_ff;
  assign o_sto_fault = sto_fault_ff;
  assign o_error_code = err_code_ff;
  assign o_limit_error = limit_ff;
endmodule // hbc_brake_ctrl
`default_nettype wire

// file: hbc_motor_model.sv
// Behavioural motor shaft with holding brake, the far side of the block.
// Assumes the bench commands shaft rotation through i_spin.
`timescale 1ns/100ps
`default_nettype none
module hbc_motor_model (
  input wire logic i_clk,
  input wire logic i_brake_release,
  input wire logic i_spin,
  output logic o_standstill
);
  // The shaft can only turn while the drive keeps the brake lifted.
  initial o_standstill = 1'b1;
  always @(posedge i_clk) begin
    o_standstill <= !(i_spin && i_brake_release);
  end
endmodule // hbc_motor_model
`default_nettype wire

// file: hbc_brake_checker.sv
// Concurrent assertions for the holding brake control block.
// Bound to hbc_brake_ctrl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module hbc_brake_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire hbc_pkg::hbc_pins_t i_pins,
  input wire hbc_pkg::hbc_limit_cfg_t i_limit_cfg,
  input wire logic i_enable_req,
  input wire logic [3:0] i_op_state,
  input wire logic [15:0] i_release_delay,
  input wire logic [15:0] i_apply_delay,
  input wire logic i_par_sel,
  input wire logic [15:0] i_par_addr,
  input wire logic [15:0] o_par_rdata,
  input wire logic o_par_ack,
  input wire logic o_par_err,
  input wire logic o_brake_release,
  input wire logic o_motor_current,
  input wire logic o_op_enable_allowed,
  input wire logic o_sto_fault,
  input wire logic [15:0] o_error_code,
  input wire logic [hbc_pkg::LIMIT_COUNT-1:0] o_limit_error
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ack_timing_a: assert property (o_par_ack == $past(i_par_sel))
    else $error("parameter ack not one cycle after select");
  unmapped_err_a: assert property (i_par_sel && i_par_addr !=
    hbc_pkg::ADDR_BRAKE_OVERRIDE_MODE |=> o_par_err && o_par_rdata == 16'h0)
    else $error("unmapped access not refused");
  release_wait_a: assert property ($rose(o_motor_current) &&
    i_release_delay != 16'h0 |-> (!o_op_enable_allowed) [*4])
    else $error("operation enabled before release delay");
  brake_apply_a: assert property ($fell(i_enable_req) && o_motor_current
    && !o_sto_fault |=> !o_brake_release)
    else $error("brake not applied after disable");
  current_hold_a: assert property ($fell(o_brake_release) &&
    o_motor_current && i_apply_delay != 16'h0 |-> o_motor_current [*4])
    else $error("current removed during apply delay");
  release_state_a: assert property ((!o_motor_current &&
    !(i_op_state inside {4'h3, 4'h4, 4'h9})) [*3] |-> !o_brake_release)
    else $error("manual release outside allowed states");
  sto_current_a: assert property ((!i_pins.torque_off_input_a) [*7]
    |-> !o_motor_current) else $error("current on under torque off");
  sto_code_a: assert property (o_sto_fault |->
    o_error_code == hbc_pkg::ERR_SAFE_TORQUE_OFF)
    else $error("wrong torque off error code");
  limit_set_a: assert property ((i_limit_cfg.enable[0] &&
    (i_pins.limit_level[0] ^ i_limit_cfg.normally_closed[0])) [*7]
    |-> o_limit_error[0]) else $error("limit trigger not reported");
endmodule // hbc_brake_checker
bind hbc_brake_ctrl hbc_brake_checker i_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_pins(i_pins), .i_limit_cfg(i_limit_cfg),
  .i_enable_req(i_enable_req), .i_op_state(i_op_state),
  .i_release_delay(i_release_delay), .i_apply_delay(i_apply_delay),
  .i_par_sel(i_par_sel), .i_par_addr(i_par_addr), .o_par_rdata(o_par_rdata),
  .o_par_ack(o_par_ack), .o_par_err(o_par_err),
  .o_brake_release(o_brake_release), .o_motor_current(o_motor_current),
  .o_op_enable_allowed(o_op_enable_allowed), .o_sto_fault(o_sto_fault),
  .o_error_code(o_error_code), .o_limit_error(o_limit_error));
`default_nettype wire

// file: hbc_brake_ctrl_test.sv
// Self-checking bench for the holding brake control block.
// Assumes a shortened millisecond unit of 4 cycles.
`timescale 1ns/100ps
`default_nettype none
module hbc_brake_ctrl_test;
  localparam logic [15:0] ADR = hbc_pkg::ADDR_BRAKE_OVERRIDE_MODE;
  localparam int BRK = 0, CUR = 1, ALW = 2, SAFE_TORQUE_OFF = 3;
  logic i_clk, i_sys_rst, i_enable_req, i_standstill, i_fault_reset, spin;
  hbc_pkg::hbc_pins_t i_pins;
  hbc_pkg::hbc_limit_cfg_t i_limit_cfg;
  logic [3:0] i_op_state;
  logic [15:0] i_release_delay, i_apply_delay, i_par_addr, i_par_wdata;
  logic i_par_sel, i_par_wr, o_par_ack, o_par_err;
  logic [15:0] o_par_rdata, o_error_code;
  logic o_brake_release, o_motor_current, o_op_enable_allowed, o_sto_fault;
  logic [1:0] o_limit_error;
  wire logic [5:0] obs = {o_limit_error, o_sto_fault, o_op_enable_allowed,
                          o_motor_current, o_brake_release};
  logic [17:0] exp_q[$];
  int num_errors = 0;
  int num_checks = 0;
  hbc_brake_ctrl #(.DELAY_UNIT_CYCLES(4)) i_dut (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_pins(i_pins), .i_limit_cfg(i_limit_cfg),
    .i_enable_req(i_enable_req), .i_op_state(i_op_state),
    .i_standstill(i_standstill), .i_fault_reset(i_fault_reset),
    .i_release_delay(i_release_delay), .i_apply_delay(i_apply_delay),
    .i_par_sel(i_par_sel), .i_par_wr(i_par_wr), .i_par_addr(i_par_addr),
    .i_par_wdata(i_par_wdata), .o_par_rdata(o_par_rdata),
    .o_par_ack(o_par_ack), .o_par_err(o_par_err),
    .o_brake_release(o_brake_release), .o_motor_current(o_motor_current),
    .o_op_enable_allowed(o_op_enable_allowed), .o_sto_fault(o_sto_fault),
    .o_error_code(o_error_code), .o_limit_error(o_limit_error));
  hbc_motor_model i_motor (.i_clk(i_clk), .i_brake_release(o_brake_release),
    .i_spin(spin), .o_standstill(i_standstill));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic close_out();
    if (num_errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Each access notes its answer; the monitor below compares it at ack.
  task automatic par(input logic wr, input logic [15:0] a,
                     input logic [15:0] d, input logic err,
                     input logic [15:0] rd);
    i_par_sel = 1'b1;
    i_par_wr = wr;
    i_par_addr = a;
    i_par_wdata = d;
    exp_q.push_back({!wr, err, rd});
    tick(1);
    i_par_sel = 1'b0;
    tick(1);
  endtask
  task automatic wait_bit(input int k, input logic v, input int n);
    int i;
    i = 0;
    while (obs[k] !== v && i < n) begin
      tick(1);
      i++;
    end
    chk(18'(obs[k]), 18'(v));
  endtask
  always @(negedge i_clk) begin
    logic [17:0] e;
    if (o_par_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(18'h1, 18'h0);
      end else begin
        e = exp_q.pop_front();
        chk({e[17], o_par_err, e[17] ? o_par_rdata : 16'h0}, e);
      end
    end
  end
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'he5ad));
    {i_sys_rst, i_pins, i_limit_cfg} = {1'b1, 5'b11001, 4'b1101};
    {i_enable_req, i_fault_reset, spin, i_par_sel, i_par_wr} = 5'h0;
    {i_par_addr, i_par_wdata} = 32'h0;
    i_op_state = hbc_pkg::OPST_OPERATION_ENABLED;
    i_release_delay = 16'h0003;
    i_apply_delay = 16'h0003;
    tick(5);
    i_sys_rst = 1'b0;
    par(1'b0, ADR, 16'h0, 1'b0, hbc_pkg::RESET_BRAKE_OVERRIDE_MODE);
    for (int m = 0; m < 3; m++) begin
      par(1'b1, ADR, 16'(m), 1'b0, 16'h0);
      par(1'b0, ADR, 16'h0, 1'b0, 16'(m));
      chk(18'(obs[BRK]), 18'h0);
    end
    par(1'b1, ADR, 16'h3 + 16'($urandom_range(0, 99)), 1'b1, 16'h0);
    par(1'b0, ADR, 16'h0, 1'b0, 16'h2);
    par(1'b0, ADR ^ 16'($urandom_range(1, 65535)), 16'h0, 1'b1, 16'h0);
    par(1'b1, ADR, 16'h0, 1'b0, 16'h0);
    i_op_state = hbc_pkg::OPST_READY_TO_SWITCH_ON;
    i_enable_req = 1'b1;
    wait_bit(CUR, 1'b1, 3);
    chk(18'(obs[BRK]), 18'h1);
    tick(8);
    chk(18'(obs[ALW]), 18'h0);
    wait_bit(ALW, 1'b1, 10);
    i_enable_req = 1'b0;
    wait_bit(BRK, 1'b0, 2);
    tick(8);
    chk(18'(obs[CUR]), 18'h1);
    wait_bit(CUR, 1'b0, 10);
    par(1'b1, ADR, 16'h2, 1'b0, 16'h0);
    i_enable_req = 1'b1;
    wait_bit(CUR, 1'b1, 3);
    tick(4);
    par(1'b1, ADR, 16'h1, 1'b0, 16'h0);
    tick(2);
    chk(18'(obs[BRK]), 18'h0);
    i_enable_req = 1'b0;
    wait_bit(CUR, 1'b0, 20);
    i_op_state = hbc_pkg::OPST_SWITCH_ON_DISABLED;
    par(1'b1, ADR, 16'h0, 1'b0, 16'h0);
    par(1'b1, ADR, 16'h1, 1'b0, 16'h0);
    wait_bit(BRK, 1'b1, 3);
    i_op_state = hbc_pkg::OPST_OPERATION_ENABLED;
    wait_bit(BRK, 1'b0, 3);
    par(1'b1, ADR, 16'h0, 1'b0, 16'h0);
    i_op_state = hbc_pkg::OPST_FAULT;
    i_pins.brake_release_input = 1'b1;
    wait_bit(BRK, 1'b1, 8);
    spin = 1'b1;
    tick(2);
    par(1'b1, ADR, 16'h2, 1'b0, 16'h0);
    tick(3);
    chk(18'(obs[BRK]), 18'h1);
    spin = 1'b0;
    wait_bit(BRK, 1'b0, 6);
    par(1'b1, ADR, 16'h0, 1'b0, 16'h0);
    wait_bit(BRK, 1'b1, 3);
    i_op_state = hbc_pkg::OPST_OPERATION_ENABLED;
    wait_bit(BRK, 1'b0, 3);
    i_pins.brake_release_input = 1'b0;
    for (int k = 0; k < 2; k++) begin
      i_pins.limit_level[k] = ~i_pins.limit_level[k];
      wait_bit(4 + k, 1'b1, 8);
      i_pins.limit_level[k] = ~i_pins.limit_level[k];
      tick(6);
      i_fault_reset = 1'b1;
      tick(1);
      i_fault_reset = 1'b0;
      wait_bit(4 + k, 1'b0, 3);
    end
    i_limit_cfg.enable = 2'b00;
    i_pins.limit_level = 2'b10;
    tick(8);
    chk(18'(o_limit_error), 18'h0);
    i_pins.limit_level = 2'b01;
    i_limit_cfg.enable = 2'b11;
    i_op_state = hbc_pkg::OPST_READY_TO_SWITCH_ON;
    i_enable_req = 1'b1;
    wait_bit(CUR, 1'b1, 3);
    i_pins.torque_off_input_a = 1'b0;
    wait_bit(SAFE_TORQUE_OFF, 1'b1, 8);
    chk({obs[CUR], obs[BRK], o_error_code}, 18'h0514);
    // The host never re-enables by itself after torque off.
    i_enable_req = 1'b0;
    i_pins.torque_off_input_a = 1'b1;
    tick(6);
    i_fault_reset = 1'b1;
    tick(1);
    i_fault_reset = 1'b0;
    wait_bit(SAFE_TORQUE_OFF, 1'b0, 3);
    tick(2);
    chk(18'(exp_q.size()), 18'h0);
    close_out();
  end
endmodule // hbc_brake_ctrl_test
`default_nettype wire
